// >>> rtl/mir_pkg.sv
// Constants and types shared by the maintenance and interrupt register bank.
package mir_pkg;

	// Host data and address widths
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	// Number of event sources per mask register
	localparam int EVT_W = 8;
	// Number of real-time line status sources
	localparam int LINE_SRC_W = 7;

	// Register offsets on the host control port
	localparam logic [ADDR_W-1:0] OFF_LOOP_LEN = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_ACT_CODE = 8'h11;
	localparam logic [ADDR_W-1:0] OFF_DEACT_CODE = 8'h12;
	localparam logic [ADDR_W-1:0] OFF_ERR_CTRL = 8'h13;
	localparam logic [ADDR_W-1:0] OFF_LINE_MASK = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_ERR_MASK = 8'h15;
	localparam logic [ADDR_W-1:0] OFF_EDGE_SEL = 8'h16;
	localparam logic [ADDR_W-1:0] OFF_LINE_STAT = 8'h17;
	localparam logic [ADDR_W-1:0] OFF_LINE_PEND = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_ERR_PEND = 8'h19;

	// Field positions in the error insert and count control register
	localparam int BIT_VIOL_INS = 6;
	localparam int BIT_PAT_PATTERN_ERROR_INSERT = 5;
	localparam int BIT_ZERO_RUN_DEF = 4;
	localparam int ERR_SRC_LSB = 2;
	localparam int BIT_REPORT_MODE = 1;
	localparam int BIT_TRANSFER = 0;

	// Field positions in the loop code length register
	localparam int ACT_LEN_LSB = 2;
	localparam int DEACT_LEN_LSB = 0;

	// Reset values
	localparam logic [DATA_W-1:0] RST_LOOP_LEN = 8'h01;
	localparam logic [DATA_W-1:0] RST_ACT_CODE = 8'h01;
	localparam logic [DATA_W-1:0] RST_DEACT_CODE = 8'h09;
	localparam logic [DATA_W-1:0] RST_ERR_CTRL = 8'h00;
	localparam logic [DATA_W-1:0] RST_MASK = 8'hff;
	localparam logic [DATA_W-1:0] RST_EDGE_SEL = 8'h00;

	// Writable bits; the others are reserved and read as zero
	localparam logic [DATA_W-1:0] WMASK_LOOP_LEN = 8'h0f;
	localparam logic [DATA_W-1:0] WMASK_ERR_CTRL = 8'h7f;
	localparam logic [DATA_W-1:0] WMASK_EDGE_SEL = 8'h7f;

	// Error counter source selection
	typedef enum logic [1:0] {
		ERR_SRC_PATTERN,
		ERR_SRC_ZERO_RUN,
		ERR_SRC_CODE_VIOL,
		ERR_SRC_BOTH
	} mir_err_src_t;

	// Loop code length selection: 5, 6, 7 or 8 bits
	typedef enum logic [1:0] {
		CODE_LEN_5,
		CODE_LEN_6,
		CODE_LEN_7,
		CODE_LEN_8
	} mir_code_len_t;

endpackage : mir_pkg

// >>> rtl/mir_evt_if.sv
// Interface between the register bank and its event pending logic.
`timescale 1ns/1ps
interface mir_evt_if #(
	parameter int N = 8
);
	logic [N-1:0] src; // Status levels or event pulses
	logic [N-1:0] edge_any; // 1: any change is an event, 0: rising only
	logic [N-1:0] clr; // One-cycle clear strobes for pending bits
	logic [N-1:0] pend; // Sticky pending bits

	// Pending logic side
	modport det (
		input src,
		input edge_any,
		input clr,
		output pend
	);

	// Register bank side
	modport ctl (
		output src,
		output edge_any,
		output clr,
		input pend
	);
endinterface : mir_evt_if

// >>> rtl/mir_event_detect.sv
// Edge detection and sticky pending bits for one group of event sources.
`timescale 1ns/1ps
module mir_event_detect #(
	parameter int N = 8,
	parameter bit PULSE_IN = 1'b0
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	mir_evt_if.det ev
);
	import mir_pkg::*;

	logic [N-1:0] prev_q; // Last sampled source level
	logic [N-1:0] prev_d;
	logic [N-1:0] pend_q; // Sticky pending bits
	logic [N-1:0] pend_d;
	logic [N-1:0] evt; // Event seen this cycle

	// Per-source event selection
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_evt
			if (PULSE_IN) begin : g_pulse
				// Source is already a one-cycle event
				assign evt[gi] = ev.src[gi];
			end else begin : g_level
				// Rising edge always counts; falling only when any-change chosen
				assign evt[gi] = (ev.src[gi] & ~prev_q[gi]) |
					(ev.edge_any[gi] & ~ev.src[gi] & prev_q[gi]);
			end
		end
	endgenerate

	// Next state: a new event wins over a clear in the same cycle
	always_comb begin
		prev_d = ev.src;
		pend_d = (pend_q & ~ev.clr) | evt;
	end

	// State registers
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prev_q <= '0;
			pend_q <= '0;
		end else begin
			prev_q <= prev_d;
			pend_q <= pend_d;
		end
	end

	assign ev.pend = pend_q;

endmodule : mir_event_detect

// >>> rtl/mir_regs.sv
// Maintenance control and interrupt mask register bank with interrupt output.
`timescale 1ns/1ps

module mir_regs (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [mir_pkg::ADDR_W-1:0] host_addr_in,
	input wire logic host_wr_in,
	input wire logic host_rd_in,
	input wire logic [mir_pkg::DATA_W-1:0] host_wdata_in,
	output logic [mir_pkg::DATA_W-1:0] host_rdata_out,
	input wire logic [mir_pkg::LINE_SRC_W-1:0] line_status_in,
	input wire logic [mir_pkg::EVT_W-1:0] error_event_in,
	output logic [mir_pkg::DATA_W-1:0] rx_activate_pattern_out,
	output logic [mir_pkg::DATA_W-1:0] rx_deactivate_pattern_out,
	output mir_pkg::mir_code_len_t activate_length_out,
	output mir_pkg::mir_code_len_t deactivate_length_out,
	output logic violation_insert_out,
	output logic pattern_error_insert_out,
	output logic zero_run_definition_out,
	output mir_pkg::mir_err_src_t error_source_out,
	output logic counter_report_mode_out,
	output logic counter_transfer_out,
	output logic irq_out
);
	import mir_pkg::*;

	// Address decode shared by writes, reads, clears and checks
	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] off);
		reg_hit = (addr == off);
	endfunction : reg_hit

	// Software-visible storage
	logic [DATA_W-1:0] loop_len_q; // Loop code lengths
	logic [DATA_W-1:0] loop_len_d;
	logic [DATA_W-1:0] act_q; // Receive activate pattern
	logic [DATA_W-1:0] act_d;
	logic [DATA_W-1:0] deact_q; // Receive deactivate pattern
	logic [DATA_W-1:0] deact_d;
	logic [DATA_W-1:0] ctrl_q; // Error insert and count control
	logic [DATA_W-1:0] ctrl_d;
	logic [DATA_W-1:0] line_mask_q; // Line event masks
	logic [DATA_W-1:0] line_mask_d;
	logic [DATA_W-1:0] err_mask_q; // Error event masks
	logic [DATA_W-1:0] err_mask_d;
	logic [DATA_W-1:0] edge_q; // Edge selects for line events
	logic [DATA_W-1:0] edge_d;

	// One-cycle action pulses
	logic viol_ins_q;
	logic viol_ins_d;
	logic pat_pattern_error_insert_q;
	logic pat_pattern_error_insert_d;
	logic transfer_q;
	logic transfer_d;

	// Read data and interrupt
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic [DATA_W-1:0] rd_mux; // Selected register for a read
	logic irq_q;
	logic irq_d;

	// Pending event groups
	logic [EVT_W-1:0] line_pend;
	logic [EVT_W-1:0] err_pend;
	logic [EVT_W-1:0] line_clr;
	logic [EVT_W-1:0] err_clr;

	mir_evt_if #(.N(EVT_W)) line_ev ();
	mir_evt_if #(.N(EVT_W)) err_ev ();

	// Line events come from status levels; top bit is reserved, never fires
	assign line_ev.src = {1'b0, line_status_in};
	assign line_ev.edge_any = edge_q;
	assign line_ev.clr = line_clr;
	assign line_pend = line_ev.pend;

	// Error events arrive as one-cycle pulses, so no edge select applies
	assign err_ev.src = error_event_in;
	assign err_ev.edge_any = '0;
	assign err_ev.clr = err_clr;
	assign err_pend = err_ev.pend;

	// Line status sources, with per-source edge selection
	mir_event_detect #(
		.N(EVT_W),
		.PULSE_IN(1'b0)
	) u_line_det (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.ev(line_ev.det)
	);

	// Error, timer and converter event sources
	mir_event_detect #(
		.N(EVT_W),
		.PULSE_IN(1'b1)
	) u_err_det (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.ev(err_ev.det)
	);

	// Register writes; reserved bits are masked off at write time, except the line mask top bit
	always_comb begin
		loop_len_d = loop_len_q;
		act_d = act_q;
		deact_d = deact_q;
		ctrl_d = ctrl_q;
		line_mask_d = line_mask_q;
		err_mask_d = err_mask_q;
		edge_d = edge_q;
		if (host_wr_in) begin
			if (reg_hit(host_addr_in, OFF_LOOP_LEN)) begin
				loop_len_d = host_wdata_in & WMASK_LOOP_LEN;
			end
			if (reg_hit(host_addr_in, OFF_ACT_CODE)) begin
				act_d = host_wdata_in;
			end
			if (reg_hit(host_addr_in, OFF_DEACT_CODE)) begin
				deact_d = host_wdata_in;
			end
			if (reg_hit(host_addr_in, OFF_ERR_CTRL)) begin
				ctrl_d = host_wdata_in & WMASK_ERR_CTRL;
			end
			if (reg_hit(host_addr_in, OFF_LINE_MASK)) begin
				// Reserved top bit is kept writable so it reads back as stored
				line_mask_d = host_wdata_in;
			end
			if (reg_hit(host_addr_in, OFF_ERR_MASK)) begin
				err_mask_d = host_wdata_in;
			end
			if (reg_hit(host_addr_in, OFF_EDGE_SEL)) begin
				edge_d = host_wdata_in & WMASK_EDGE_SEL;
			end
		end
	end

	// Action pulses fire only on a 0 to 1 change of the stored bit
	always_comb begin
		viol_ins_d = 1'b0;
		pat_pattern_error_insert_d = 1'b0;
		transfer_d = 1'b0;
		if (host_wr_in && reg_hit(host_addr_in, OFF_ERR_CTRL)) begin
			// Rewriting a 1 does nothing; software must clear first
			viol_ins_d = host_wdata_in[BIT_VIOL_INS] & ~ctrl_q[BIT_VIOL_INS];
			pat_pattern_error_insert_d = host_wdata_in[BIT_PAT_PATTERN_ERROR_INSERT] &
				~ctrl_q[BIT_PAT_PATTERN_ERROR_INSERT];
			transfer_d = host_wdata_in[BIT_TRANSFER] & ~ctrl_q[BIT_TRANSFER];
		end
	end

	// Write-one-to-clear strobes for the pending registers
	always_comb begin
		line_clr = '0;
		err_clr = '0;
		if (host_wr_in && reg_hit(host_addr_in, OFF_LINE_PEND)) begin
			line_clr = host_wdata_in;
		end
		if (host_wr_in && reg_hit(host_addr_in, OFF_ERR_PEND)) begin
			err_clr = host_wdata_in;
		end
	end

	// Read selection; unmapped offsets read as zero
	always_comb begin
		unique case (1'b1)
			reg_hit(host_addr_in, OFF_LOOP_LEN): rd_mux = loop_len_q;
			reg_hit(host_addr_in, OFF_ACT_CODE): rd_mux = act_q;
			reg_hit(host_addr_in, OFF_DEACT_CODE): rd_mux = deact_q;
			reg_hit(host_addr_in, OFF_ERR_CTRL): rd_mux = ctrl_q;
			reg_hit(host_addr_in, OFF_LINE_MASK): rd_mux = line_mask_q;
			reg_hit(host_addr_in, OFF_ERR_MASK): rd_mux = err_mask_q;
			reg_hit(host_addr_in, OFF_EDGE_SEL): rd_mux = edge_q;
			reg_hit(host_addr_in, OFF_LINE_STAT): rd_mux = {1'b0, line_status_in};
			reg_hit(host_addr_in, OFF_LINE_PEND): rd_mux = line_pend;
			reg_hit(host_addr_in, OFF_ERR_PEND): rd_mux = err_pend;
			default: rd_mux = '0;
		endcase
		// Read data holds between reads so slow hosts can sample late
		rdata_d = host_rd_in ? rd_mux : rdata_q;
	end

	// Interrupt: any pending source whose mask bit is 0
	always_comb begin
		// Line group: loop codes, sync, clock loss, driver, alarm, loss
		// Error group: shaper, jitter buffer, pattern, zeros, violations, timer, counter
		irq_d = (|(line_pend & ~line_mask_q)) |
			(|(err_pend & ~err_mask_q));
	end

	// Register all state
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			loop_len_q <= RST_LOOP_LEN;
			act_q <= RST_ACT_CODE;
			deact_q <= RST_DEACT_CODE;
			ctrl_q <= RST_ERR_CTRL;
			line_mask_q <= RST_MASK;
			err_mask_q <= RST_MASK;
			edge_q <= RST_EDGE_SEL;
			viol_ins_q <= 1'b0;
			pat_pattern_error_insert_q <= 1'b0;
			transfer_q <= 1'b0;
			rdata_q <= '0;
			irq_q <= 1'b0;
		end else begin
			loop_len_q <= loop_len_d;
			act_q <= act_d;
			deact_q <= deact_d;
			ctrl_q <= ctrl_d;
			line_mask_q <= line_mask_d;
			err_mask_q <= err_mask_d;
			edge_q <= edge_d;
			viol_ins_q <= viol_ins_d;
			pat_pattern_error_insert_q <= pat_pattern_error_insert_d;
			transfer_q <= transfer_d;
			rdata_q <= rdata_d;
			irq_q <= irq_d;
		end
	end

	// Outputs, all from flip-flops
	assign host_rdata_out = rdata_q;
	assign rx_activate_pattern_out = act_q;
	assign rx_deactivate_pattern_out = deact_q;
	assign activate_length_out = mir_code_len_t'(loop_len_q[ACT_LEN_LSB +: 2]);
	assign deactivate_length_out = mir_code_len_t'(loop_len_q[DEACT_LEN_LSB +: 2]);
	assign violation_insert_out = viol_ins_q;
	assign pattern_error_insert_out = pat_pattern_error_insert_q;
	assign zero_run_definition_out = ctrl_q[BIT_ZERO_RUN_DEF];
	assign error_source_out = mir_err_src_t'(ctrl_q[ERR_SRC_LSB +: 2]);
	assign counter_report_mode_out = ctrl_q[BIT_REPORT_MODE];
	assign counter_transfer_out = transfer_q;
	assign irq_out = irq_q;

	// Checks
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	// Writes that raise an insert or transfer bit
	sequence viol_rise_s;
		host_wr_in && reg_hit(host_addr_in, OFF_ERR_CTRL) &&
			host_wdata_in[BIT_VIOL_INS] && !ctrl_q[BIT_VIOL_INS];
	endsequence
	sequence pat_rise_s;
		host_wr_in && reg_hit(host_addr_in, OFF_ERR_CTRL) &&
			host_wdata_in[BIT_PAT_PATTERN_ERROR_INSERT] && !ctrl_q[BIT_PAT_PATTERN_ERROR_INSERT];
	endsequence
	sequence xfer_rise_s;
		host_wr_in && reg_hit(host_addr_in, OFF_ERR_CTRL) &&
			host_wdata_in[BIT_TRANSFER] && !ctrl_q[BIT_TRANSFER];
	endsequence

	viol_pulse_a: assert property (viol_rise_s |=> violation_insert_out ##1 !violation_insert_out)
		else $error("violation insert pulse wrong");
	viol_cause_a: assert property (violation_insert_out |-> $past(viol_ins_d)
		&& ctrl_q[BIT_VIOL_INS])
		else $error("violation insert without rising bit");
	pat_pulse_a: assert property (pat_rise_s |=> pattern_error_insert_out ##1 !pattern_error_insert_out)
		else $error("pattern error insert pulse wrong");
	xfer_pulse_a: assert property (xfer_rise_s |=> counter_transfer_out ##1 !counter_transfer_out)
		else $error("counter transfer pulse wrong");
	mask_reset_a: assert property ($rose(rst_n_in) |-> line_mask_q == 8'hff && err_mask_q == 8'hff)
		else $error("mask registers not all ones after reset");
	code_reset_a: assert property ($rose(rst_n_in) |-> act_q == 8'h01 && deact_q == 8'h09
		&& activate_length_out == CODE_LEN_5 && deactivate_length_out == CODE_LEN_6
		&& !counter_report_mode_out)
		else $error("code or control reset value wrong");
	rise_event_a: assert property ($past(rst_n_in) && line_status_in[0]
		&& !$past(line_status_in[0]) |=> line_pend[0])
		else $error("rising status did not set pending");
	fall_event_a: assert property ($past(rst_n_in) && edge_q[1] && !line_status_in[1]
		&& $past(line_status_in[1]) |=> line_pend[1])
		else $error("falling status with any-change did not set pending");
	set_wins_a: assert property (error_event_in[0] |=> err_pend[0])
		else $error("error event lost against clear");
	irq_on_a: assert property (|(err_pend & ~err_mask_q) |=> irq_out)
		else $error("unmasked event did not raise interrupt");
	irq_off_a: assert property ((line_pend & ~line_mask_q) == 8'h00
		&& (err_pend & ~err_mask_q) == 8'h00 |=> !irq_out)
		else $error("interrupt raised with all events masked");
	readback_a: assert property (host_rd_in && reg_hit(host_addr_in, OFF_ERR_CTRL)
		|=> host_rdata_out == $past(ctrl_q) && host_rdata_out[7] == 1'b0)
		else $error("control register readback wrong");

endmodule : mir_regs

// >>> verif/mir_regs_bench.sv
// Self-checking bench for the maintenance and interrupt register bank.
`timescale 1ns/1ps
module mir_regs_bench;
	import mir_pkg::*;

	logic ref_clk_in = 1'b0; // 100 MHz host clock
	logic rst_n_in = 1'b0; // Active-low reset
	logic [ADDR_W-1:0] host_addr_in = 8'h00;
	logic host_wr_in = 1'b0;
	logic host_rd_in = 1'b0;
	logic [DATA_W-1:0] host_wdata_in = 8'h00;
	logic [DATA_W-1:0] host_rdata_out;
	logic [LINE_SRC_W-1:0] line_status_in = 7'h00; // Status levels
	logic [EVT_W-1:0] error_event_in = 8'h00; // Event pulses
	logic [DATA_W-1:0] act_out;
	logic [DATA_W-1:0] deact_out;
	mir_code_len_t act_len_out;
	mir_code_len_t deact_len_out;
	logic viol_out;
	logic perr_out;
	logic zdef_out;
	mir_err_src_t src_out;
	logic mode_out;
	logic xfer_out;
	logic irq_out;
	int num_errors = 0; // Mismatches seen
	int num_checks = 0; // Comparisons made

	// Free-running clock, 10 ns period
	always #5 ref_clk_in = ~ref_clk_in;

	mir_regs dut_u (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.host_addr_in(host_addr_in),
		.host_wr_in(host_wr_in),
		.host_rd_in(host_rd_in),
		.host_wdata_in(host_wdata_in),
		.host_rdata_out(host_rdata_out),
		.line_status_in(line_status_in),
		.error_event_in(error_event_in),
		.rx_activate_pattern_out(act_out),
		.rx_deactivate_pattern_out(deact_out),
		.activate_length_out(act_len_out),
		.deactivate_length_out(deact_len_out),
		.violation_insert_out(viol_out),
		.pattern_error_insert_out(perr_out),
		.zero_run_definition_out(zdef_out),
		.error_source_out(src_out),
		.counter_report_mode_out(mode_out),
		.counter_transfer_out(xfer_out),
		.irq_out(irq_out)
	);

	// Compare a byte-wide result; case inequality so unknowns fail
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check8

	// Compare a single-bit result
	task automatic check1(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check1

	// Print counts and verdict, then stop
	task automatic test_done;
		$display("checks=%0d mismatches=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done

	// One-cycle write strobe; returns at the taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		host_wr_in <= 1'b1;
		host_addr_in <= a;
		host_wdata_in <= d;
		@(posedge ref_clk_in);
		host_wr_in <= 1'b0;
	endtask : wr

	// One-cycle read strobe; data is settled just after the taking edge
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk_in);
		host_rd_in <= 1'b1;
		host_addr_in <= a;
		@(posedge ref_clk_in);
		host_rd_in <= 1'b0;
		#1;
		check8(host_rdata_out, e);
	endtask : rd_chk

	// Drive status levels, then wait until irq would have answered
	task automatic set_status(input logic [6:0] v);
		@(posedge ref_clk_in);
		line_status_in <= v;
		repeat (2) @(posedge ref_clk_in);
		#1;
	endtask : set_status

	// One-cycle error event pulse, then wait for irq
	task automatic pulse_evt(input logic [7:0] v);
		@(posedge ref_clk_in);
		error_event_in <= v;
		@(posedge ref_clk_in);
		error_event_in <= 8'h00;
		@(posedge ref_clk_in);
		#1;
	endtask : pulse_evt

	// Writable bits per offset; reserved bits must read zero
	function automatic logic [7:0] wmask(input logic [7:0] a);
		case (a)
			OFF_LOOP_LEN: wmask = 8'h0f;
			OFF_ERR_CTRL: wmask = 8'h7f;
			OFF_EDGE_SEL: wmask = 8'h7f;
			default: wmask = 8'hff;
		endcase
	endfunction : wmask

	// Watchdog: a hang counts as a mismatch; bound kept well under 100k cycles
	initial begin
		#600000;
		num_errors++;
		test_done();
	end

	// Main sequence
	initial begin
		logic [7:0] v;
		logic [7:0] a;
		int i;
		int k;
		void'($urandom(25446));
		repeat (2) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		// Reset values at the outputs and in the register map
		#1;
		check8(act_out, 8'h01);
		check8(deact_out, 8'h09);
		check8({6'h00, act_len_out}, 8'h00);
		check8({6'h00, deact_len_out}, 8'h01);
		check1(mode_out, 1'b0);
		check1(irq_out, 1'b0);
		rd_chk(OFF_LOOP_LEN, 8'h01);
		rd_chk(OFF_ACT_CODE, 8'h01);
		rd_chk(OFF_DEACT_CODE, 8'h09);
		rd_chk(OFF_ERR_CTRL, 8'h00);
		rd_chk(OFF_LINE_MASK, 8'hff);
		rd_chk(OFF_ERR_MASK, 8'hff);
		rd_chk(OFF_EDGE_SEL, 8'h00);
		$display("test reset_values done");
		// Random write and read-back over every writable offset
		for (i = 0; i < 40; i++) begin
			a = OFF_LOOP_LEN + 8'($urandom_range(6));
			v = 8'($urandom);
			wr(a, v);
			#1;
			if (a == OFF_ACT_CODE) check8(act_out, v);
			if (a == OFF_DEACT_CODE) check8(deact_out, v);
			if (a == OFF_LOOP_LEN) check8({6'h00, act_len_out}, {6'h00, v[3:2]});
			if (a == OFF_LOOP_LEN) check8({6'h00, deact_len_out}, {6'h00, v[1:0]});
			if (a == OFF_ERR_CTRL) check1(zdef_out, v[4]);
			if (a == OFF_ERR_CTRL) check8({6'h00, src_out}, {6'h00, v[3:2]});
			if (a == OFF_ERR_CTRL) check1(mode_out, v[1]);
			rd_chk(a, v & wmask(a));
		end
		// Unmapped reads give zero; read-only status ignores writes
		rd_chk(8'h20, 8'h00);
		wr(OFF_LINE_STAT, 8'h7f);
		rd_chk(OFF_LINE_STAT, 8'h00);
		$display("test register_access done");
		// One pulse per rising edge of each insert or transfer bit
		wr(OFF_ERR_CTRL, 8'h00);
		wr(OFF_ERR_CTRL, 8'h41);
		#1;
		check1(viol_out, 1'b1);
		check1(xfer_out, 1'b1);
		check1(perr_out, 1'b0);
		@(posedge ref_clk_in);
		#1;
		check1(viol_out, 1'b0);
		check1(xfer_out, 1'b0);
		wr(OFF_ERR_CTRL, 8'h41);
		#1;
		check1(viol_out, 1'b0);
		check1(xfer_out, 1'b0);
		wr(OFF_ERR_CTRL, 8'h00);
		wr(OFF_ERR_CTRL, 8'h20);
		#1;
		check1(perr_out, 1'b1);
		check1(viol_out, 1'b0);
		@(posedge ref_clk_in);
		#1;
		check1(perr_out, 1'b0);
		$display("test insert_pulses done");
		// Each line source: unmasked rise raises irq, a fall with rising-only select does not
		wr(OFF_LINE_MASK, 8'hff);
		wr(OFF_ERR_MASK, 8'hff);
		wr(OFF_EDGE_SEL, 8'h00);
		for (i = 0; i < 7; i++) begin
			wr(OFF_LINE_PEND, 8'hff);
			wr(OFF_LINE_MASK, ~(8'h01 << i));
			set_status(7'h7f & ~(7'h01 << i));
			check1(irq_out, 1'b0);
			set_status(7'h7f);
			check1(irq_out, 1'b1);
			wr(OFF_LINE_PEND, 8'h01 << i);
			set_status(7'h00);
			check1(irq_out, 1'b0);
			wr(OFF_LINE_MASK, 8'hff);
		end
		// Any-change select: a falling status raises the event
		k = $urandom_range(6);
		set_status(7'h01 << k);
		wr(OFF_LINE_PEND, 8'hff);
		wr(OFF_EDGE_SEL, 8'h01 << k);
		wr(OFF_LINE_MASK, ~(8'h01 << k));
		set_status(7'h00);
		check1(irq_out, 1'b1);
		wr(OFF_LINE_MASK, 8'hff);
		repeat (2) @(posedge ref_clk_in);
		#1;
		check1(irq_out, 1'b0);
		$display("test line_irq done");
		// Each error source: others masked leave irq low, own bit raises it
		for (i = 0; i < 8; i++) begin
			wr(OFF_ERR_PEND, 8'hff);
			wr(OFF_ERR_MASK, ~(8'h01 << i));
			pulse_evt(~(8'h01 << i));
			check1(irq_out, 1'b0);
			pulse_evt(8'h01 << i);
			check1(irq_out, 1'b1);
			wr(OFF_ERR_PEND, 8'hff);
			repeat (2) @(posedge ref_clk_in);
			#1;
			check1(irq_out, 1'b0);
			wr(OFF_ERR_MASK, 8'hff);
		end
		// Event and clear taken at one edge: the event must stay pending
		wr(OFF_ERR_MASK, 8'hfe);
		@(posedge ref_clk_in);
		host_wr_in <= 1'b1;
		host_addr_in <= OFF_ERR_PEND;
		host_wdata_in <= 8'hff;
		error_event_in <= 8'h01;
		@(posedge ref_clk_in);
		host_wr_in <= 1'b0;
		error_event_in <= 8'h00;
		@(posedge ref_clk_in);
		#1;
		check1(irq_out, 1'b1);
		rd_chk(OFF_ERR_PEND, 8'h01);
		wr(OFF_ERR_PEND, 8'hff);
		wr(OFF_ERR_MASK, 8'hff);
		$display("test error_irq done");
		// Mid-run reset restores the line mask and the control register
		@(posedge ref_clk_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		rd_chk(OFF_LINE_MASK, 8'hff);
		rd_chk(OFF_ERR_CTRL, 8'h00);
		$display("test second_reset done");
		test_done();
	end
endmodule : mir_regs_bench
